// ---- rtl/pasp_pkg.sv ----
package pasp_pkg;
   // Command encodings on the link
   typedef enum logic [2:0] {
      PASP_CMD_NOP,
      PASP_CMD_ACT,
      PASP_CMD_RD,
      PASP_CMD_WR,
      PASP_CMD_MWR,
      PASP_CMD_PRE,
      PASP_CMD_PREA
   } pasp_cmd_t;

   localparam int unsigned PASP_BANKS     = 8;
   localparam int unsigned PASP_BA_W      = 3;
   localparam int unsigned PASP_CNT_W     = 8;
   localparam int unsigned PASP_MR_W      = 8;

   // Clock and picosecond timings
   localparam int unsigned PASP_TCK_PS    = 50000;
   localparam int unsigned PASP_TWR_PS    = 18000;
   localparam int unsigned PASP_TRPPB_PS  = 18000;
   localparam int unsigned PASP_TWTR_PS   = 10000;
   localparam int unsigned PASP_TRTP_PS   = 7500;

   function automatic int unsigned pasp_ru(input int unsigned ps);
      int unsigned c;
      c = (ps + PASP_TCK_PS - 1) / PASP_TCK_PS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int unsigned PASP_TWR_CK    = pasp_ru(PASP_TWR_PS);
   localparam int unsigned PASP_TRPPB_CK  = pasp_ru(PASP_TRPPB_PS);
   localparam int unsigned PASP_TWTR_CK   = pasp_ru(PASP_TWTR_PS);
   localparam int unsigned PASP_TRTP_CK   = pasp_ru(PASP_TRTP_PS);

   localparam int unsigned PASP_PRE_PRE   = 4;
   localparam int unsigned PASP_BL32_XTRA = 8;
   localparam int unsigned PASP_BL16      = 16;
   localparam int unsigned PASP_BL32      = 32;

   // Mode register bits
   localparam int unsigned PASP_MR1_WPRE_BIT = 2;
   localparam int unsigned PASP_MR1_RPST_BIT = 7;

   // APB register map of the controller end
   localparam logic [7:0] PASP_REG_CMD    = 8'h00;
   localparam logic [7:0] PASP_REG_STAT   = 8'h04;
   localparam logic [7:0] PASP_REG_TIMA   = 8'h08;
   localparam logic [7:0] PASP_REG_TIMB   = 8'h0C;
   localparam logic [7:0] PASP_REG_MODE   = 8'h10;

   // CMD register fields
   localparam int unsigned PASP_F_CMD_LSB = 0;
   localparam int unsigned PASP_F_BA_LSB  = 4;
   localparam int unsigned PASP_F_AP_BIT  = 8;

   // Reset values
   // WL, nWR and nRTP here must agree with the device end's parameters
   localparam logic [31:0] PASP_TIMA_RST  = 32'h0006_0803;
   localparam logic [31:0] PASP_TIMB_RST  = 32'h0000_0003;
   localparam logic [31:0] PASP_MODE_RST  = 32'h0000_0000;
endpackage

// ---- rtl/pasp_if.sv ----
`timescale 1ns/1ps
interface pasp_if;
   import pasp_pkg::*;
   logic [2:0]           cmd;
   logic [PASP_BA_W-1:0] ba;
   logic                 ap;
   logic                 bl32;
   logic                 busy;
   logic                 viol;
   logic [PASP_BANKS-1:0] pre_start;

   modport ctrl (output cmd, ba, ap, bl32, input busy, viol, pre_start);
   modport dev  (input cmd, ba, ap, bl32, output busy, viol, pre_start);
endinterface

// ---- rtl/pasp_dev.sv ----
`timescale 1ns/1ps
// Device end: executes the command stream, times each burst (a new burst restarts the count) and
// starts auto-precharge on its own; flags illegal spacing.
module pasp_dev #(
   parameter int unsigned WL    = 6,
   parameter int unsigned NWR   = 8,
   parameter int unsigned NRTP  = 3
) (
   // Clock and reset
   input  wire logic                 CLK_SYS_IN,
   input  wire logic                 RESET_N_IN,
   // Link
   pasp_if.dev                       LINK,
   // Mode register inputs
   input  wire logic [7:0]           MR1_IN,
   // User side
   output logic                      VIOL_OUT,
   output logic [7:0]                BANK_OPEN_OUT
);
   import pasp_pkg::*;

   logic [PASP_BANKS-1:0]  open_ff;
   logic [PASP_BANKS-1:0]  pend_ff;
   logic [PASP_CNT_W-1:0]  apcnt_ff [PASP_BANKS];
   logic [PASP_CNT_W-1:0]  burst_ff;
   logic [PASP_BANKS-1:0]  pre_ff;
   logic                   viol_ff;
   pasp_cmd_t              cmd;
   logic [PASP_CNT_W-1:0]  half_bl;
   logic [PASP_CNT_W-1:0]  wr_ap_dly;
   logic [PASP_CNT_W-1:0]  rd_ap_dly;
   logic                   is_burst;
   logic                   is_wr;

   assign cmd       = pasp_cmd_t'(LINK.cmd);
   assign half_bl   = LINK.bl32 ? PASP_CNT_W'(PASP_BL32 / 2) : PASP_CNT_W'(PASP_BL16 / 2);
   assign wr_ap_dly = PASP_CNT_W'(WL) + half_bl + PASP_CNT_W'(NWR) + 8'h01;
   assign rd_ap_dly = PASP_CNT_W'(NRTP)
                      + (LINK.bl32 ? PASP_CNT_W'(PASP_BL32_XTRA) : 8'h00);
   assign is_wr     = (cmd == PASP_CMD_WR) || (cmd == PASP_CMD_MWR);
   assign is_burst  = is_wr || (cmd == PASP_CMD_RD);

   // A new burst to another bank is accepted gapless once the current one is done
   always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         burst_ff <= 8'h00;
         viol_ff  <= 1'b0;
      end else begin
         viol_ff <= is_burst && (burst_ff > 8'h01);
         if (is_burst)
            burst_ff <= half_bl;
         else if (burst_ff != 8'h00)
            burst_ff <= burst_ff - 8'h01;
      end
   end

   for (genvar b = 0; b < PASP_BANKS; b++) begin : g_bank
      logic hit;
      assign hit = (LINK.ba == PASP_BA_W'(b));
      always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
         if (!RESET_N_IN) begin
            open_ff[b]  <= 1'b0;
            pend_ff[b]  <= 1'b0;
            apcnt_ff[b] <= 8'h00;
            pre_ff[b]   <= 1'b0;
         end else begin
            pre_ff[b] <= 1'b0;
            if (pend_ff[b]) begin
               if (apcnt_ff[b] <= 8'h01) begin
                  pend_ff[b] <= 1'b0;
                  open_ff[b] <= 1'b0;
                  pre_ff[b]  <= 1'b1;
               end else
                  apcnt_ff[b] <= apcnt_ff[b] - 8'h01;
            end
            if (cmd == PASP_CMD_ACT && hit)
               open_ff[b] <= 1'b1;
            else if ((cmd == PASP_CMD_PRE && hit) || cmd == PASP_CMD_PREA) begin
               open_ff[b] <= 1'b0;
               pre_ff[b]  <= 1'b1;
            end else if (is_burst && hit && LINK.ap) begin
               pend_ff[b]  <= 1'b1;
               apcnt_ff[b] <= is_wr ? wr_ap_dly : rd_ap_dly;
            end
         end
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         VIOL_OUT      <= 1'b0;
         BANK_OPEN_OUT <= 8'h00;
      end else begin
         VIOL_OUT      <= viol_ff;
         BANK_OPEN_OUT <= 8'(open_ff);
      end
   end

   assign LINK.busy      = (burst_ff > 8'h01);
   assign LINK.viol      = viol_ff;
   assign LINK.pre_start = pre_ff;
   // Preamble and postamble selections only shape the controller's spacing
   logic unused_mr;
   assign unused_mr = MR1_IN[PASP_MR1_WPRE_BIT] ^ MR1_IN[PASP_MR1_RPST_BIT];
endmodule

// ---- rtl/pasp_ctrl.sv ----
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module pasp_ctrl (
   // Clock and reset
   input  wire logic                 CLK_SYS_IN,
   input  wire logic                 RESET_N_IN,
   // APB slave
   input  wire logic                 PSEL_IN,
   input  wire logic                 PENABLE_IN,
   input  wire logic                 PWRITE_IN,
   input  wire logic [7:0]           PADDR_IN,
   input  wire logic [31:0]          PWDATA_IN,
   output logic [31:0]               PRDATA_OUT,
   output logic                      PREADY_OUT,
   output logic                      PSLVERR_OUT,
   // Link
   pasp_if.ctrl                      LINK,
   // Mode register copy driven to device
   output logic [7:0]                MR1_OUT
);
   import pasp_pkg::*;

   typedef enum logic [1:0] {PASP_S_IDLE, PASP_S_WAIT, PASP_S_ISSUE} pasp_st_t;

   logic [31:0]            tima_ff;
   logic [31:0]            timb_ff;
   logic [31:0]            mode_ff;
   logic [8:0]             req_ff;
   pasp_st_t               st_ff;
   logic [PASP_CNT_W-1:0]  same_ff [PASP_BANKS];
   logic [PASP_CNT_W-1:0]  act_ff  [PASP_BANKS];
   logic [PASP_CNT_W-1:0]  rd_oth_ff;
   logic [PASP_CNT_W-1:0]  wr_oth_ff;
   logic [PASP_CNT_W-1:0]  pre_ff;
   logic [2:0]             cmd_ff;
   logic [PASP_BA_W-1:0]   ba_ff;
   logic                   ap_ff;
   logic                   rej_ff;
   logic [31:0]            rdata_ff;
   logic                   ready_ff;
   logic                   slverr_ff;

   // Timing fields: TIMA = {RL, WL, nWR, nRTP}, TIMB = {ODTLon, tODTon, tDQSCK}
   logic [7:0] f_wl, f_nwr, f_nrtp, f_rl, f_dqsck, f_odton, f_odtlon;
   assign f_nrtp   = tima_ff[7:0];
   assign f_nwr    = tima_ff[15:8];
   assign f_wl     = tima_ff[23:16];
   assign f_rl     = tima_ff[31:24];
   assign f_dqsck  = timb_ff[7:0];
   assign f_odton  = timb_ff[15:8];
   assign f_odtlon = timb_ff[23:16];

   logic bl32, odt_en, wpre2, rpst15;
   assign bl32   = mode_ff[0];
   assign odt_en = mode_ff[1];
   assign wpre2  = mode_ff[8 + PASP_MR1_WPRE_BIT];
   assign rpst15 = mode_ff[8 + PASP_MR1_RPST_BIT];

   logic [7:0] half_bl, wr_ap_pre, rd_ap_pre, rd2wr, wtr_ck, rpst_ck, wpre_ck;
   assign half_bl   = bl32 ? 8'(PASP_BL32 / 2) : 8'(PASP_BL16 / 2);
   assign wtr_ck    = 8'(PASP_TWTR_CK);
   assign rpst_ck   = rpst15 ? 8'h02 : 8'h01;
   assign wpre_ck   = wpre2 ? 8'h02 : 8'h01;
   assign wr_ap_pre = f_wl + half_bl + f_nwr + 8'h01;
   assign rd_ap_pre = f_nrtp + (bl32 ? 8'(PASP_BL32_XTRA) : 8'h00);
   assign rd2wr     = odt_en ?
                      f_rl + f_dqsck + half_bl + rpst_ck - f_odtlon - f_odton + 8'h01 :
                      f_rl + f_dqsck + half_bl + rpst_ck - f_wl + wpre_ck;

   function automatic logic [7:0] pasp_max(input logic [7:0] a, input logic [7:0] b);
      return (a > b) ? a : b;
   endfunction

   // Request decode
   pasp_cmd_t            r_cmd;
   logic [PASP_BA_W-1:0] r_ba;
   logic                 r_ap, r_wr, r_rd, r_pre, r_ok, r_bad;
   // Banks still inside a same-bank lockout; precharge-all must wait for all of them
   wire  [PASP_BANKS-1:0] same_nz;
   assign r_cmd = pasp_cmd_t'(req_ff[2:0]);
   assign r_ba  = req_ff[PASP_F_BA_LSB +: PASP_BA_W];
   assign r_ap  = req_ff[PASP_F_AP_BIT];
   assign r_wr  = (r_cmd == PASP_CMD_WR) || (r_cmd == PASP_CMD_MWR);
   assign r_rd  = (r_cmd == PASP_CMD_RD);
   assign r_pre = (r_cmd == PASP_CMD_PRE) || (r_cmd == PASP_CMD_PREA);
   // Write-then-read-AP must cover write recovery
   logic wr_rec_ok;
   assign wr_rec_ok = (wtr_ck + f_nrtp + (bl32 ? 8'(PASP_BL32_XTRA) : 8'h00))
                      >= 8'(PASP_TWR_CK);
   assign r_bad = r_rd && r_ap && !wr_rec_ok;
   assign r_ok  = (same_ff[r_ba] == 8'h00)
               && !(r_cmd == PASP_CMD_ACT && act_ff[r_ba] != 8'h00)
               && !(r_rd && rd_oth_ff != 8'h00)
               && !(r_wr && wr_oth_ff != 8'h00)
               && !(r_pre && pre_ff != 8'h00)
               && !(r_cmd == PASP_CMD_PREA && same_nz != 8'h00)
               && !LINK.busy;

   logic issue;
   assign issue = (st_ff == PASP_S_WAIT) && r_ok && !r_bad;

   always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         st_ff <= PASP_S_IDLE;
         rej_ff <= 1'b0;
      end else begin
         case (st_ff)
            PASP_S_IDLE: if (PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == PASP_REG_CMD)
                            st_ff <= PASP_S_WAIT;
            PASP_S_WAIT: begin
               if (r_bad) begin
                  rej_ff <= 1'b1;
                  st_ff  <= PASP_S_IDLE;
               end else if (r_ok) begin
                  rej_ff <= 1'b0;
                  st_ff  <= PASP_S_ISSUE;
               end
            end
            PASP_S_ISSUE: st_ff <= PASP_S_IDLE;
            default: st_ff <= PASP_S_IDLE;
         endcase
      end
   end

   // Global spacing counters
   always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         rd_oth_ff <= 8'h00;
         wr_oth_ff <= 8'h00;
         pre_ff    <= 8'h00;
      end else begin
         rd_oth_ff <= (rd_oth_ff != 8'h00) ? rd_oth_ff - 8'h01 : 8'h00;
         wr_oth_ff <= (wr_oth_ff != 8'h00) ? wr_oth_ff - 8'h01 : 8'h00;
         pre_ff    <= (pre_ff != 8'h00) ? pre_ff - 8'h01 : 8'h00;
         if (issue && r_pre)
            pre_ff <= 8'(PASP_PRE_PRE - 1);
         if (issue && r_wr) begin
            wr_oth_ff <= half_bl - 8'h01;
            rd_oth_ff <= f_wl + half_bl + wtr_ck;
         end
         if (issue && r_rd) begin
            rd_oth_ff <= half_bl - 8'h01;
            wr_oth_ff <= pasp_max(rd2wr, 8'h01) - 8'h01;
         end
      end
   end

   // Per-bank timers: same-bank lockout and activate lockout
   for (genvar b = 0; b < PASP_BANKS; b++) begin : g_bank
      logic hit;
      assign hit = (r_ba == PASP_BA_W'(b));
      assign same_nz[b] = (same_ff[b] != 8'h00);
      always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
         if (!RESET_N_IN) begin
            same_ff[b] <= 8'h00;
            act_ff[b]  <= 8'h00;
         end else begin
            same_ff[b] <= (same_ff[b] != 8'h00) ? same_ff[b] - 8'h01 : 8'h00;
            act_ff[b]  <= (act_ff[b] != 8'h00) ? act_ff[b] - 8'h01 : 8'h00;
            if (issue && hit && (r_wr || r_rd) && r_ap) begin
               same_ff[b] <= (r_wr ? wr_ap_pre : rd_ap_pre) - 8'h01;
               act_ff[b]  <= (r_wr ? wr_ap_pre : rd_ap_pre)
                             + 8'(PASP_TRPPB_CK) - 8'h01;
            end
            if (issue && r_pre && (hit || r_cmd == PASP_CMD_PREA))
               act_ff[b] <= 8'(PASP_TRPPB_CK) - 8'h01;
         end
      end
   end

   // Link drive and APB registers
   always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         cmd_ff <= 3'h0;
         ba_ff  <= 3'h0;
         ap_ff  <= 1'b0;
      end else begin
         cmd_ff <= issue ? req_ff[2:0] : 3'h0;
         ba_ff  <= issue ? r_ba : ba_ff;
         ap_ff  <= issue & r_ap;
      end
   end

   logic acc, wr_en;
   assign acc   = PSEL_IN && PENABLE_IN;
   assign wr_en = acc && PWRITE_IN;

   always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         tima_ff <= PASP_TIMA_RST;
         timb_ff <= PASP_TIMB_RST;
         mode_ff <= PASP_MODE_RST;
         req_ff  <= 9'h000;
      end else if (wr_en) begin
         case (PADDR_IN)
            PASP_REG_CMD:  if (st_ff == PASP_S_IDLE) req_ff <= PWDATA_IN[8:0];
            PASP_REG_TIMA: tima_ff <= PWDATA_IN;
            PASP_REG_TIMB: timb_ff <= PWDATA_IN;
            PASP_REG_MODE: mode_ff <= PWDATA_IN;
            default: ;
         endcase
      end
   end

   logic        map_ok;
   logic [31:0] rmux;
   assign map_ok = (PADDR_IN == PASP_REG_CMD) || (PADDR_IN == PASP_REG_STAT) ||
                   (PADDR_IN == PASP_REG_TIMA) || (PADDR_IN == PASP_REG_TIMB) ||
                   (PADDR_IN == PASP_REG_MODE);
   assign rmux = (PADDR_IN == PASP_REG_CMD)  ? {23'h000000, req_ff} :
                 (PADDR_IN == PASP_REG_STAT) ? {28'h0000000, LINK.viol, rej_ff,
                                                LINK.busy, st_ff != PASP_S_IDLE} :
                 (PADDR_IN == PASP_REG_TIMA) ? tima_ff :
                 (PADDR_IN == PASP_REG_TIMB) ? timb_ff :
                 (PADDR_IN == PASP_REG_MODE) ? mode_ff : 32'h00000000;

   always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         rdata_ff  <= 32'h00000000;
         ready_ff  <= 1'b0;
         slverr_ff <= 1'b0;
         MR1_OUT   <= 8'h00;
      end else begin
         ready_ff  <= PSEL_IN && !PENABLE_IN;
         slverr_ff <= PSEL_IN && !PENABLE_IN && !map_ok;
         rdata_ff  <= rmux;
         MR1_OUT   <= mode_ff[15:8];
      end
   end

   assign PRDATA_OUT  = rdata_ff;
   assign PREADY_OUT  = ready_ff;
   assign PSLVERR_OUT = slverr_ff;
   assign LINK.cmd    = cmd_ff;
   assign LINK.ba     = ba_ff;
   assign LINK.ap     = ap_ff;
   assign LINK.bl32   = bl32;
endmodule

// ---- bench/pasp_monitor.sv ----
`timescale 1ns/1ps
module pasp_monitor
   import pasp_pkg::*;
#(
   parameter int unsigned WL   = 6,
   parameter int unsigned NWR  = 8,
   parameter int unsigned NRTP = 3
) (
   // Clock and reset
   input wire logic                  CLK_SYS_IN,
   input wire logic                  RESET_N_IN,
   // Link
   input wire logic [2:0]            cmd,
   input wire logic [PASP_BA_W-1:0]  ba,
   input wire logic                  ap,
   input wire logic                  bl32,
   input wire logic                  busy,
   input wire logic                  viol,
   input wire logic [PASP_BANKS-1:0] pre_start
);
   localparam int WAP16 = WL + PASP_BL16 / 2 + NWR + 1;
   localparam int WAP32 = WL + PASP_BL32 / 2 + NWR + 1;
   // The precharge pulse shows one clock after the edge on which it begins
   localparam int WPS16 = WAP16 + 1;
   localparam int WPS32 = WAP32 + 1;
   localparam int RAP16 = NRTP + 1;
   localparam int RAP32 = NRTP + PASP_BL32_XTRA + 1;
   localparam int TRP   = PASP_TRPPB_CK;

   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RESET_N_IN);

   wire            is_wr  = (cmd == PASP_CMD_WR) || (cmd == PASP_CMD_MWR);
   wire            is_wap = is_wr && ap;
   wire            is_pre = (cmd == PASP_CMD_PRE) || (cmd == PASP_CMD_PREA);
   wire            is_rap = (cmd == PASP_CMD_RD) && ap;
   // Counters hold the forbidden cycles left after a write with auto-precharge
   wire [7:0]      wap_load = bl32 ? 8'(WAP32 + TRP - 1) : 8'(WAP16 + TRP - 1);
   wire [7:0]      wtr_load = bl32 ? 8'(WAP32 - NWR + PASP_TWTR_CK - 1)
                                   : 8'(WAP16 - NWR + PASP_TWTR_CK - 1);
   logic [7:0]     wap_cnt_ff;
   logic [7:0]     wtr_cnt_ff;
   logic [2:0]     wap_ba_ff;
   wire [7:0]      nxt_wap_cnt = is_wap ? wap_load : wap_cnt_ff - 8'(wap_cnt_ff != 8'h00);
   wire [7:0]      nxt_wtr_cnt = is_wap ? wtr_load : wtr_cnt_ff - 8'(wtr_cnt_ff != 8'h00);
   wire [2:0]      nxt_wap_ba  = is_wap ? ba : wap_ba_ff;

   always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         wap_cnt_ff <= 8'h00;
         wtr_cnt_ff <= 8'h00;
         wap_ba_ff  <= 3'h0;
      end else begin
         wap_cnt_ff <= nxt_wap_cnt;
         wtr_cnt_ff <= nxt_wtr_cnt;
         wap_ba_ff  <= nxt_wap_ba;
      end
   end

   property p_pre_pre; is_pre |=> !is_pre [*3]; endproperty
   a_pre_pre: assert property (p_pre_pre) else $error("precharges too close");
   property p_wap_pre;
      wap_cnt_ff > 8'(TRP) |-> !(cmd == PASP_CMD_PREA || (cmd == PASP_CMD_PRE && ba == wap_ba_ff));
   endproperty
   a_wap_pre: assert property (p_wap_pre) else $error("early precharge");
   property p_wap_act;
      wap_cnt_ff != 8'h00 |-> !(cmd == PASP_CMD_ACT && ba == wap_ba_ff);
   endproperty
   a_wap_act: assert property (p_wap_act) else $error("early activate");
   property p_wap_wr; is_wap && !bl32 |=> !is_wr [*7]; endproperty
   a_wap_wr: assert property (p_wap_wr) else $error("early write");
   property p_wap_rd; wtr_cnt_ff != 8'h00 |-> cmd != PASP_CMD_RD; endproperty
   a_wap_rd: assert property (p_wap_rd) else $error("early read");
   property p_wap16; is_wap && !bl32 |-> ##WPS16 pre_start[$past(ba, WPS16)]; endproperty
   a_wap16: assert property (p_wap16) else $error("write auto-precharge late");
   property p_wap32; is_wap && bl32 |-> ##WPS32 pre_start[$past(ba, WPS32)]; endproperty
   a_wap32: assert property (p_wap32) else $error("long write auto-precharge late");
   property p_rap16; is_rap && !bl32 |-> ##RAP16 pre_start[$past(ba, RAP16)]; endproperty
   a_rap16: assert property (p_rap16) else $error("read auto-precharge late");
   property p_rap32; is_rap && bl32 |-> ##RAP32 pre_start[$past(ba, RAP32)]; endproperty
   a_rap32: assert property (p_rap32) else $error("long read auto-precharge late");
   property p_no_cut; $rose(busy) |-> !viol [*8]; endproperty
   a_no_cut: assert property (p_no_cut) else $error("burst cut short");

   c_wap16: cover property (is_wap && !bl32);
   c_wap32: cover property (is_wap && bl32);
   c_rap: cover property (is_rap);
   c_prea: cover property (cmd == PASP_CMD_PREA);
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   import pasp_pkg::*;
   logic        clk;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic        note;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire  [7:0]  mr1;
   wire         viol;
   wire  [7:0]  bank_open;
   int          fail_count = 0;
   int          check_count = 0;
   int          cyc = 0;
   integer      seed = 15;
   logic [32:0] exp_rd[$];
   logic [7:0]  exp_pre[$];
   logic [7:0]  e_pre;

   pasp_if pasp_if_inst();
   pasp_ctrl pasp_ctrl_inst(.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel),
      .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
      .LINK(pasp_if_inst), .MR1_OUT(mr1));
   pasp_dev pasp_dev_inst(.CLK_SYS_IN(clk), .RESET_N_IN(rst_n),
      .LINK(pasp_if_inst), .MR1_IN(mr1), .VIOL_OUT(viol), .BANK_OPEN_OUT(bank_open));
   pasp_monitor pasp_monitor_inst(.CLK_SYS_IN(clk),
      .RESET_N_IN(rst_n), .cmd(pasp_if_inst.cmd), .ba(pasp_if_inst.ba), .ap(pasp_if_inst.ap),
      .bl32(pasp_if_inst.bl32), .busy(pasp_if_inst.busy), .viol(pasp_if_inst.viol),
      .pre_start(pasp_if_inst.pre_start));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      if (fail_count == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic nt, output logic [31:0] q);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      note    <= nt;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      note    <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      exp_rd.push_back({1'b0, e});
      apb(1'b0, a, 32'h0, 1'b1, q);
   endtask

   // Waits for the previous command to leave the controller, then posts the next
   task automatic issue(input pasp_cmd_t c, input logic [2:0] b, input logic a);
      logic [31:0] q;
      do begin
         apb(1'b0, PASP_REG_STAT, 32'h0, 1'b0, q);
      end while (q[0] !== 1'b0);
      apb(1'b1, PASP_REG_CMD, {23'h0, a, 1'b0, b, 1'b0, c}, 1'b0, q);
   endtask

   task automatic drain();
      int n;
      n = 0;
      while (exp_pre.size() != 0 && n < 500) begin
         @(posedge clk);
         n++;
      end
      check(33'(exp_pre.size()), 33'h0);
   endtask

   always @(posedge clk) begin
      if (rst_n === 1'b1 && psel && penable && pready === 1'b1 && note) begin
         check({pslverr, pwrite ? 32'h0 : prdata}, exp_rd.pop_front());
      end
      if (rst_n === 1'b1 && pasp_if_inst.pre_start !== 8'h00) begin
         e_pre = (exp_pre.size() != 0) ? exp_pre.pop_front() : 8'h00;
         check({25'h0, pasp_if_inst.pre_start}, {25'h0, e_pre});
      end
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fail_count++;
         final_report();
      end
   end

   initial begin : main
      logic [31:0] q;
      logic [31:0] w;
      logic [7:0]  m;
      rst_n = 1'b0;
      {psel, penable, pwrite, note} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd_chk(PASP_REG_TIMA, PASP_TIMA_RST);
      rd_chk(PASP_REG_TIMB, PASP_TIMB_RST);
      rd_chk(PASP_REG_MODE, PASP_MODE_RST);
      exp_rd.push_back({1'b1, 32'h0});
      apb(1'b1, 8'h20, 32'h0, 1'b1, q);
      for (int bl = 0; bl < 2; bl++) begin
         m = 8'($random(seed));
         w = {16'h0, m, 6'h0, 1'($random(seed)), 1'(bl)};
         apb(1'b1, PASP_REG_MODE, w, 1'b0, q);
         rd_chk(PASP_REG_MODE, w);
         check({25'h0, mr1}, {25'h0, m});
         for (int b = 0; b < 8; b++) issue(PASP_CMD_ACT, 3'(b), 1'b0);
         repeat (4) @(posedge clk);
         check({25'h0, bank_open}, 33'h0FF);
         for (int b = 0; b < 8; b++) begin
            exp_pre.push_back(8'h01 << b);
            issue(1'($random(seed)) ? PASP_CMD_MWR : PASP_CMD_WR, 3'(b), 1'b1);
         end
         for (int b = 0; b < 8; b++) issue(PASP_CMD_ACT, 3'(b), 1'b0);
         for (int b = 0; b < 8; b++) begin
            exp_pre.push_back(8'h01 << b);
            issue(PASP_CMD_RD, 3'(b), 1'b1);
         end
         issue(PASP_CMD_ACT, 3'h2, 1'b0);
         exp_pre.push_back(8'h04);
         exp_pre.push_back(8'hFF);
         issue(PASP_CMD_PRE, 3'h2, 1'b0);
         issue(PASP_CMD_PREA, 3'h0, 1'b0);
         drain();
      end
      rd_chk(PASP_REG_STAT, 32'h0);
      check({32'h0, viol}, 33'h0);
      check({25'h0, bank_open}, 33'h0);
      final_report();
   end
endmodule
